// ===== pkg/lpc_defs.svh
// Register offsets, reset values, field positions and scale constants of the limiter/PLL/PDM bank.
`ifndef LPC_DEFS_SVH
`define LPC_DEFS_SVH

`define LPC_OFS_PLL_FRAC_LO 8'h0A
`define LPC_OFS_KNEE 8'h0B
`define LPC_OFS_SLOPE 8'h0C
`define LPC_OFS_TRIM 8'h0D
`define LPC_OFS_ATK_HYS 8'h0E
`define LPC_OFS_REL 8'h0F
`define LPC_OFS_INTEG 8'h10
`define LPC_OFS_PDM 8'h11

`define LPC_RST_PLL_FRAC_LO 8'h00
`define LPC_RST_KNEE 8'h8F
`define LPC_RST_SLOPE 8'h80
`define LPC_RST_TRIM 8'hBE
`define LPC_RST_ATK_HYS 8'h08
`define LPC_RST_REL 8'h04
`define LPC_RST_INTEG 8'h00
`define LPC_RST_PDM 8'h01

`define LPC_TRIM_INIT 8'hA9
`define LPC_ATK_INIT_BIT 5
`define LPC_FRAC_MAX 14'h270F

`define LPC_KNEE_MIN 8'h6D
`define LPC_KNEE_MAX 8'hFE
`define LPC_KNEE_STEP_UV 17330
`define LPC_KNEE_BASE_MV 3000
`define LPC_SLOPE_BASE_MVV 1200
`define LPC_SLOPE_STEP_UVV 37300
`define LPC_ATK_BASE_US 20
`define LPC_ATK_STEP_US 350
`define LPC_REL_BASE_MS 50
`define LPC_REL_STEP_MS 105

`define LPC_HYS_0_UV 0
`define LPC_HYS_1_UV 4360
`define LPC_HYS_2_UV 13080
`define LPC_HYS_3_UV 30520
`define LPC_VPT_0_MV 2500
`define LPC_VPT_STEP_MV 200

`endif

// ===== pkg/lpc_pkg.sv
// Types shared by the limiter/PLL/PDM configuration bank.
package lpc_pkg;

	typedef enum logic [1:0] {
		LPC_PDM_PLL_DIV8 = 2'h0,
		LPC_PDM_SENSE_CLK = 2'h1,
		LPC_PDM_BIT_CLK = 2'h2,
		LPC_PDM_MASTER_CLK = 2'h3
	} lpc_pdm_src_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lpc_req_t;

	typedef struct packed {
		logic [1:0] hysteresis;
		logic [2:0] attack_rate;
		logic [1:0] passthrough_disable_vbat;
		logic [3:0] limiter_release_rate;
		logic [5:0] integration_count;
		logic [1:0] integration_updown_ratio;
		logic [7:0] knee_code;
		logic [7:0] slope_code;
		logic knee_valid;
	} lpc_limiter_cfg_t;

	typedef struct packed {
		logic [15:0] knee_mv;
		logic [15:0] slope_mvv;
		logic [15:0] hysteresis_uv;
		logic [15:0] passthrough_vbat_mv;
		logic [11:0] attack_us_per_db;
		logic [11:0] release_ms_per_db;
		logic [15:0] updown_span;
	} lpc_limiter_scaled_t;

	typedef struct packed {
		lpc_pdm_src_t clock_source;
		logic ch1_rising;
		logic ch2_rising;
	} lpc_pdm_cfg_t;

endpackage

// ===== design/lpc_limiter_scale.sv
// Converts limiter register codes into physical magnitudes for the limiter datapath.
`timescale 1ns/1ps
`include "lpc_defs.svh"

module lpc_limiter_scale (
	input wire lpc_pkg::lpc_limiter_cfg_t cfg_i, // Raw limiter codes.
	output lpc_pkg::lpc_limiter_scaled_t scaled_o // Scaled magnitudes.
);

	function automatic logic [15:0] lpc_lin(input logic [31:0] base, input logic [31:0] step,
			input logic [31:0] code, input logic [31:0] div);
		logic [31:0] v;
		v = base + (step * code) / div;
		return v[15:0];
	endfunction

	always_comb begin
		scaled_o = '0;
		if (cfg_i.knee_valid) begin
			scaled_o.knee_mv = lpc_lin(`LPC_KNEE_BASE_MV, `LPC_KNEE_STEP_UV,
				32'(cfg_i.knee_code - `LPC_KNEE_MIN), 1000);
		end
		scaled_o.slope_mvv = lpc_lin(`LPC_SLOPE_BASE_MVV, `LPC_SLOPE_STEP_UVV,
			32'(cfg_i.slope_code), 1000);
		case (cfg_i.hysteresis)
			2'h0: scaled_o.hysteresis_uv = 16'(`LPC_HYS_0_UV);
			2'h1: scaled_o.hysteresis_uv = 16'(`LPC_HYS_1_UV);
			2'h2: scaled_o.hysteresis_uv = 16'(`LPC_HYS_2_UV);
			default: scaled_o.hysteresis_uv = 16'(`LPC_HYS_3_UV);
		endcase
		scaled_o.passthrough_vbat_mv = lpc_lin(`LPC_VPT_0_MV, `LPC_VPT_STEP_MV,
			32'(cfg_i.passthrough_disable_vbat), 1);
		scaled_o.attack_us_per_db = 12'(lpc_lin(`LPC_ATK_BASE_US, `LPC_ATK_STEP_US,
			32'(cfg_i.attack_rate), 1));
		scaled_o.release_ms_per_db = 12'(lpc_lin(`LPC_REL_BASE_MS, `LPC_REL_STEP_MS,
			32'(cfg_i.limiter_release_rate), 1));
		scaled_o.updown_span = 16'h0001 << {cfg_i.integration_updown_ratio, 1'b0};
	end

endmodule

// ===== design/lpc_limiter_integrator.sv
// Integration filter that gates limiter gain changes on repeated threshold crossings.
`timescale 1ns/1ps
`include "lpc_defs.svh"

module lpc_limiter_integrator (
	input wire logic ref_clk_i, // Device clock.
	input wire logic sys_rst_i, // Synchronous reset, active high.
	input wire logic sample_i, // One-cycle pulse per output peak sample.
	input wire logic above_i, // Sample exceeded the limit threshold.
	input wire logic [5:0] integration_count_i, // Peaks needed before a trigger.
	input wire logic [15:0] updown_span_i, // Low samples per decrement.
	output logic trigger_o // Registered pulse: start attack or decay.
);

	logic [5:0] level_r, level_nxt;
	logic [15:0] low_r, low_nxt;
	logic trigger_r, trigger_nxt;

	// The down count is slower than the up count for a nonzero ratio so brief dips do not disarm it.
	always_comb begin
		level_nxt = level_r;
		low_nxt = low_r;
		trigger_nxt = 1'b0;
		if (sample_i) begin
			if (above_i) begin
				low_nxt = 16'h0000;
				if (level_r >= integration_count_i) begin
					trigger_nxt = 1'b1;
					level_nxt = 6'h00;
				end else begin
					level_nxt = level_r + 6'h01;
				end
			end else if (low_r + 16'h0001 >= updown_span_i) begin
				low_nxt = 16'h0000;
				if (level_r != 6'h00) begin
					level_nxt = level_r - 6'h01;
				end
			end else begin
				low_nxt = low_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			level_r <= 6'h00;
			low_r <= 16'h0000;
			trigger_r <= 1'b0;
		end else begin
			level_r <= level_nxt;
			low_r <= low_nxt;
			trigger_r <= trigger_nxt;
		end
	end

	assign trigger_o = trigger_r;

endmodule

// ===== design/lpc_config_regs.sv
// Limiter, PLL fraction and PDM configuration register bank with its decoded outputs.
//
// Function
// - Fraction is six upper bits from elsewhere joined with this byte as LSB.
// - Knee code steps 0.01733 V; 0x6D is 3.00 V, 0xFE is 5.51 V.
// - Slope code zero is 1.2 V/V, plus 0.0373 V/V per step.
// - Hysteresis codes give none, 4.36, 13.08, 30.52 mV before release re-arms.
// - Below selected battery threshold, pass-through is off and boost stays on.
// - Attack rate is 20 us/dB plus 350 us/dB per code.
// - Release rate is 50 ms/dB plus 105 ms/dB per code; reset 0100.
// - Integration count sets peaks above limit needed before a gain change.
// - Count decrements only after four-to-the-ratio low samples.
// - Edge select puts channel 1 on falling (0) or rising (1); channel 2 opposite.
// - Clock source: PLL/8, sense clock, bit clock, master clock; reset 01.
// - Fraction writes take effect only while the PLL is disabled.
// - PLL output is half input times J.D over two to the P.
`timescale 1ns/1ps
`include "lpc_defs.svh"

module lpc_config_regs (
	input wire logic ref_clk_i, // Device clock, 125 MHz.
	input wire logic sys_rst_i, // Synchronous reset, active high.
	input wire lpc_pkg::lpc_req_t req_i, // Register access from the serial control port.
	output logic [7:0] rdata_o, // Registered read data.
	output logic rvalid_o, // Read data valid, one cycle.
	output logic hit_o, // Access addressed this bank (combinational).
	input wire logic pll_enable_i, // PLL enable from the power control register.
	input wire logic [5:0] pll_frac_high_i, // Upper fraction bits held elsewhere.
	output logic [13:0] pll_fraction_o, // Fraction applied to the PLL.
	output logic pll_fraction_invalid_o, // Applied fraction exceeds 9999.
	input wire logic [15:0] vbat_mv_i, // Measured battery voltage in mV.
	output logic passthrough_inhibit_o, // Force boost on, pass-through disabled.
	output lpc_pkg::lpc_limiter_cfg_t limiter_cfg_o, // Raw limiter fields.
	output lpc_pkg::lpc_limiter_scaled_t limiter_scaled_o, // Scaled limiter values.
	input wire logic peak_sample_i, // Output peak sample strobe.
	input wire logic peak_above_i, // Sample above the limit threshold.
	output logic limiter_trigger_o, // Start an attack or decay step.
	output logic [7:0] trim_o, // Reserved trim byte to analog.
	output logic init_trim_bit_o, // Bit 5 of attack/hysteresis register.
	output lpc_pkg::lpc_pdm_cfg_t pdm_cfg_o // PDM clock source and edges.
);

	logic [7:0] frac_lo_r, frac_lo_nxt;
	logic [7:0] knee_r, knee_nxt;
	logic [7:0] slope_r, slope_nxt;
	logic [7:0] trim_r, trim_nxt;
	logic [7:0] atk_r, atk_nxt;
	logic [7:0] rel_r, rel_nxt;
	logic [7:0] integ_r, integ_nxt;
	logic [7:0] pdm_r, pdm_nxt;
	logic [13:0] frac_act_r, frac_act_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;
	logic inhibit_r, inhibit_nxt;
	lpc_pkg::lpc_limiter_cfg_t cfg;
	lpc_pkg::lpc_limiter_scaled_t scaled;

	function automatic logic lpc_decode(input logic [7:0] a);
		return (a >= `LPC_OFS_PLL_FRAC_LO) && (a <= `LPC_OFS_PDM);
	endfunction

	assign hit_o = lpc_decode(req_i.addr);

	// Storage holds whatever the host writes, reserved bits included.
	// Each register is its own group so one write strobe can only ever touch one byte.
	function automatic logic lpc_wr_hit(input lpc_pkg::lpc_req_t r, input logic [7:0] ofs);
		return r.wr && (r.addr == ofs);
	endfunction

	// The stored byte follows the host at once; only the PLL copy further down waits.
	always_comb begin
		frac_lo_nxt = frac_lo_r;
		if (lpc_wr_hit(req_i, `LPC_OFS_PLL_FRAC_LO)) begin
			frac_lo_nxt = req_i.wdata;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			frac_lo_r <= `LPC_RST_PLL_FRAC_LO;
		end else begin
			frac_lo_r <= frac_lo_nxt;
		end
	end

	always_comb begin
		knee_nxt = knee_r;
		if (lpc_wr_hit(req_i, `LPC_OFS_KNEE)) begin
			knee_nxt = req_i.wdata;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			knee_r <= `LPC_RST_KNEE;
		end else begin
			knee_r <= knee_nxt;
		end
	end

	always_comb begin
		slope_nxt = slope_r;
		if (lpc_wr_hit(req_i, `LPC_OFS_SLOPE)) begin
			slope_nxt = req_i.wdata;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			slope_r <= `LPC_RST_SLOPE;
		end else begin
			slope_r <= slope_nxt;
		end
	end

	always_comb begin
		trim_nxt = trim_r;
		if (lpc_wr_hit(req_i, `LPC_OFS_TRIM)) begin
			trim_nxt = req_i.wdata;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			trim_r <= `LPC_RST_TRIM;
		end else begin
			trim_r <= trim_nxt;
		end
	end

	// Bit 5 is stored like any other bit; the host is expected to set it at start-up.
	always_comb begin
		atk_nxt = atk_r;
		if (lpc_wr_hit(req_i, `LPC_OFS_ATK_HYS)) begin
			atk_nxt = req_i.wdata;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			atk_r <= `LPC_RST_ATK_HYS;
		end else begin
			atk_r <= atk_nxt;
		end
	end

	always_comb begin
		rel_nxt = rel_r;
		if (lpc_wr_hit(req_i, `LPC_OFS_REL)) begin
			rel_nxt = req_i.wdata;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rel_r <= `LPC_RST_REL;
		end else begin
			rel_r <= rel_nxt;
		end
	end

	always_comb begin
		integ_nxt = integ_r;
		if (lpc_wr_hit(req_i, `LPC_OFS_INTEG)) begin
			integ_nxt = req_i.wdata;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			integ_r <= `LPC_RST_INTEG;
		end else begin
			integ_r <= integ_nxt;
		end
	end

	always_comb begin
		pdm_nxt = pdm_r;
		if (lpc_wr_hit(req_i, `LPC_OFS_PDM)) begin
			pdm_nxt = req_i.wdata;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			pdm_r <= `LPC_RST_PDM;
		end else begin
			pdm_r <= pdm_nxt;
		end
	end

	// Read port answers one cycle after the request.
	always_comb begin
		rvalid_nxt = req_i.rd && hit_o;
		rdata_nxt = 8'h00;
		if (req_i.rd) begin
			case (req_i.addr)
				`LPC_OFS_PLL_FRAC_LO: rdata_nxt = frac_lo_r;
				`LPC_OFS_KNEE: rdata_nxt = knee_r;
				`LPC_OFS_SLOPE: rdata_nxt = slope_r;
				`LPC_OFS_TRIM: rdata_nxt = trim_r;
				`LPC_OFS_ATK_HYS: rdata_nxt = atk_r;
				`LPC_OFS_REL: rdata_nxt = rel_r;
				`LPC_OFS_INTEG: rdata_nxt = integ_r;
				`LPC_OFS_PDM: rdata_nxt = pdm_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	assign rdata_o = rdata_r;
	assign rvalid_o = rvalid_r;

	// The PLL sees a frozen copy so a half-written fraction never reaches a running loop.
	always_comb begin
		frac_act_nxt = frac_act_r;
		if (!pll_enable_i) begin
			frac_act_nxt = {pll_frac_high_i, frac_lo_r};
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			frac_act_r <= {6'h00, `LPC_RST_PLL_FRAC_LO};
		end else begin
			frac_act_r <= frac_act_nxt;
		end
	end

	assign pll_fraction_o = frac_act_r;
	assign pll_fraction_invalid_o = frac_act_r > `LPC_FRAC_MAX;

	// Limiter field extraction.
	always_comb begin
		cfg = '0;
		cfg.hysteresis = atk_r[7:6];
		cfg.passthrough_disable_vbat = atk_r[4:3];
		cfg.attack_rate = atk_r[2:0];
		cfg.limiter_release_rate = rel_r[3:0];
		cfg.integration_updown_ratio = integ_r[7:6];
		cfg.integration_count = integ_r[5:0];
		cfg.knee_code = knee_r;
		cfg.slope_code = slope_r;
		cfg.knee_valid = (knee_r >= `LPC_KNEE_MIN) && (knee_r <= `LPC_KNEE_MAX);
	end

	assign limiter_cfg_o = cfg;
	assign trim_o = trim_r;
	assign init_trim_bit_o = atk_r[`LPC_ATK_INIT_BIT];

	lpc_limiter_scale u_scale (
		.cfg_i(cfg),
		.scaled_o(scaled)
	);

	assign limiter_scaled_o = scaled;

	// Registered compare keeps the boost control free of glitches from the ADC word.
	always_comb begin
		inhibit_nxt = vbat_mv_i < scaled.passthrough_vbat_mv;
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			inhibit_r <= 1'b0;
		end else begin
			inhibit_r <= inhibit_nxt;
		end
	end

	assign passthrough_inhibit_o = inhibit_r;

	lpc_limiter_integrator u_integ (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.sample_i(peak_sample_i),
		.above_i(peak_above_i),
		.integration_count_i(cfg.integration_count),
		.updown_span_i(scaled.updown_span),
		.trigger_o(limiter_trigger_o)
	);

	// Reserved PDM bits are stored but steer nothing.
	always_comb begin
		pdm_cfg_o.clock_source = lpc_pkg::lpc_pdm_src_t'(pdm_r[1:0]);
		pdm_cfg_o.ch1_rising = pdm_r[2];
		pdm_cfg_o.ch2_rising = ~pdm_r[2];
	end

endmodule

// ===== verification/lpc_config_regs_props.sv
// Concurrent checks on the ports of the limiter, PLL fraction and PDM bank.
`timescale 1ns/1ps
module lpc_config_regs_props (
	input wire logic ref_clk_i, // Clock.
	input wire logic sys_rst_i, // Reset.
	input wire lpc_pkg::lpc_req_t req_i, // Request.
	input wire logic [7:0] rdata_o, // Read data.
	input wire logic rvalid_o, // Read valid.
	input wire logic hit_o, // Bank hit.
	input wire logic pll_enable_i, // PLL enable.
	input wire logic [5:0] pll_frac_high_i, // Upper fraction.
	input wire logic [13:0] pll_fraction_o, // Applied fraction.
	input wire logic [15:0] vbat_mv_i, // Battery.
	input wire logic passthrough_inhibit_o, // Inhibit.
	input wire lpc_pkg::lpc_limiter_cfg_t limiter_cfg_o, // Raw fields.
	input wire lpc_pkg::lpc_limiter_scaled_t limiter_scaled_o, // Scaled.
	input wire logic peak_sample_i, // Peak strobe.
	input wire logic peak_above_i, // Peak above.
	input wire logic limiter_trigger_o, // Trigger.
	input wire lpc_pkg::lpc_pdm_cfg_t pdm_cfg_o // PDM config.
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_read_ans; req_i.rd && hit_o |=> rvalid_o; endproperty
	a_read_ans: assert property (p_read_ans) else $error("read not answered");
	property p_unmapped; req_i.rd && !hit_o |=> !rvalid_o && rdata_o == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
	property p_frac_copy; !pll_enable_i |=> pll_fraction_o[13:8] == $past(pll_frac_high_i); endproperty
	a_frac_copy: assert property (p_frac_copy) else $error("fraction high bits wrong");
	property p_frac_hold; pll_enable_i |=> $stable(pll_fraction_o); endproperty
	a_frac_hold: assert property (p_frac_hold) else $error("fraction moved while enabled");
	property p_inhibit;
		!$past(sys_rst_i) |-> passthrough_inhibit_o ==
			$past(vbat_mv_i < 16'h09C4 + 16'h00C8 * limiter_cfg_o.passthrough_disable_vbat);
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("inhibit wrong");
	property p_knee_ok;
		limiter_cfg_o.knee_valid == (limiter_cfg_o.knee_code inside {[8'h6D:8'hFE]});
	endproperty
	a_knee_ok: assert property (p_knee_ok) else $error("knee validity wrong");
	property p_release;
		limiter_scaled_o.release_ms_per_db == 12'h032 + 12'h069 * limiter_cfg_o.limiter_release_rate;
	endproperty
	a_release: assert property (p_release) else $error("release rate wrong");
	property p_pdm_edge; pdm_cfg_o.ch2_rising != pdm_cfg_o.ch1_rising; endproperty
	a_pdm_edge: assert property (p_pdm_edge) else $error("channel edges equal");
	property p_trig;
		peak_sample_i && peak_above_i && limiter_cfg_o.integration_count == 6'h00 |=> limiter_trigger_o;
	endproperty
	a_trig: assert property (p_trig) else $error("trigger missing");
	property p_hit; hit_o == (req_i.addr inside {[8'h0A:8'h11]}); endproperty
	a_hit: assert property (p_hit) else $error("bank hit wrong");
endmodule

bind lpc_config_regs lpc_config_regs_props u_props (.ref_clk_i, .sys_rst_i, .req_i, .rdata_o,
	.rvalid_o, .hit_o, .pll_enable_i, .pll_frac_high_i, .pll_fraction_o, .vbat_mv_i,
	.passthrough_inhibit_o, .limiter_cfg_o, .limiter_scaled_o, .peak_sample_i, .peak_above_i,
	.limiter_trigger_o, .pdm_cfg_o);

// ===== verification/lpc_host_model.sv
// Host model that issues register accesses on the serial control port.
`timescale 1ns/1ps
module lpc_host_model (
	input wire logic ref_clk_i, // Clock.
	input wire logic [7:0] rdata_i, // Read data.
	output lpc_pkg::lpc_req_t req_o // Request.
);
	initial req_o = '0;
	// A released request shows inverted lines so stale values cannot pass for fresh ones.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		#1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk_i);
		#1 req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		#1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge ref_clk_i);
		#1 req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
		d = rdata_i;
	endtask
	task automatic init();
		logic [7:0] v;
		wr(8'h0D, 8'hA9);
		rd(8'h0E, v);
		wr(8'h0E, v | 8'h20);
	endtask
endmodule

// ===== verification/lpc_config_regs_tb.sv
// Self-checking bench for the limiter, PLL fraction and PDM configuration bank.
`timescale 1ns/1ps
module lpc_config_regs_tb;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic pll_enable_i = 1'b0;
	logic [5:0] pll_frac_high_i = 6'h00;
	logic [15:0] vbat_mv_i = 16'h1000;
	logic peak_sample_i = 1'b0;
	logic peak_above_i = 1'b0;
	lpc_pkg::lpc_req_t req_i;
	logic [7:0] rdata_o, trim_o, d;
	logic rvalid_o, pll_fraction_invalid_o, passthrough_inhibit_o, limiter_trigger_o;
	logic init_trim_bit_o;
	logic [13:0] pll_fraction_o;
	lpc_pkg::lpc_limiter_cfg_t limiter_cfg_o;
	lpc_pkg::lpc_limiter_scaled_t limiter_scaled_o;
	lpc_pkg::lpc_pdm_cfg_t pdm_cfg_o;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #4 ref_clk_i = ~ref_clk_i;
	lpc_host_model host (.ref_clk_i, .rdata_i(rdata_o), .req_o(req_i));
	lpc_config_regs uut (.ref_clk_i, .sys_rst_i, .req_i, .rdata_o, .rvalid_o, .hit_o(),
		.pll_enable_i, .pll_frac_high_i, .pll_fraction_o, .pll_fraction_invalid_o, .vbat_mv_i,
		.passthrough_inhibit_o, .limiter_cfg_o, .limiter_scaled_o, .peak_sample_i,
		.peak_above_i, .limiter_trigger_o, .trim_o, .init_trim_bit_o, .pdm_cfg_o);
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic t_reset();
		logic [7:0] rv [8] = '{8'h00, 8'h8F, 8'h80, 8'hBE, 8'h08, 8'h04, 8'h00, 8'h01};
		for (int i = 0; i < 8; i++) begin
			host.rd(8'h0A + i[7:0], d);
			chk("reset value", {8'h00, d}, {8'h00, rv[i]});
			chk("read valid", {15'h0000, rvalid_o}, 16'h0001);
		end
		chk("pdm source", {14'h0000, pdm_cfg_o.clock_source}, 16'h0001);
		chk("vpt code", {14'h0000, limiter_cfg_o.passthrough_disable_vbat}, 16'h0001);
	endtask
	// Reserved fields of the release and PDM registers keep their reset values.
	function automatic logic [7:0] rw_val(input int i);
		logic [7:0] v;
		v = 8'h5A ^ i[7:0];
		if (i == 5)
			v = v & 8'h0F;
		if (i == 7)
			v = v & 8'h07;
		return v;
	endfunction
	task automatic t_rw();
		for (int i = 0; i < 8; i++)
			host.wr(8'h0A + i[7:0], rw_val(i));
		for (int i = 0; i < 8; i++) begin
			host.rd(8'h0A + i[7:0], d);
			chk("readback", {8'h00, d}, {8'h00, rw_val(i)});
		end
		host.rd(8'h12, d);
		chk("unmapped data", {8'h00, d}, 16'h0000);
		chk("unmapped valid", {15'h0000, rvalid_o}, 16'h0000);
		host.init();
		chk("trim", {8'h00, trim_o}, 16'h00A9);
		chk("init bit", {15'h0000, init_trim_bit_o}, 16'h0001);
	endtask
	task automatic t_scale();
		host.wr(8'h0B, 8'h6D);
		host.wr(8'h0C, 8'h00);
		host.wr(8'h0E, 8'hE7);
		host.wr(8'h0F, 8'h0F);
		host.wr(8'h10, 8'hC0);
		chk("knee", limiter_scaled_o.knee_mv, 16'h0BB8);
		chk("slope", limiter_scaled_o.slope_mvv, 16'h04B0);
		chk("hysteresis", limiter_scaled_o.hysteresis_uv, 16'h7738);
		chk("attack", {4'h0, limiter_scaled_o.attack_us_per_db}, 16'h09A6);
		chk("release", {4'h0, limiter_scaled_o.release_ms_per_db}, 16'h0659);
		chk("span", limiter_scaled_o.updown_span, 16'h0040);
		host.wr(8'h0B, 8'hFF);
		chk("knee valid", {15'h0000, limiter_cfg_o.knee_valid}, 16'h0000);
		chk("knee reserved", limiter_scaled_o.knee_mv, 16'h0000);
	endtask
	task automatic t_pdm();
		for (int i = 0; i < 8; i++) begin
			host.wr(8'h11, i[7:0]);
			chk("pdm src", {14'h0000, pdm_cfg_o.clock_source}, {14'h0000, i[1:0]});
			chk("ch1 edge", {15'h0000, pdm_cfg_o.ch1_rising}, {15'h0000, i[2]});
			chk("ch2 edge", {15'h0000, pdm_cfg_o.ch2_rising}, {15'h0000, ~i[2]});
		end
	endtask
	task automatic t_pll();
		host.wr(8'h0A, 8'h0F);
		pll_frac_high_i = 6'h27;
		step(2);
		chk("fraction", {2'h0, pll_fraction_o}, 16'h270F);
		chk("frac ok", {15'h0000, pll_fraction_invalid_o}, 16'h0000);
		pll_enable_i = 1'b1;
		host.wr(8'h0A, 8'h10);
		step(2);
		chk("frozen", {2'h0, pll_fraction_o}, 16'h270F);
		pll_enable_i = 1'b0;
		step(2);
		chk("updated", {2'h0, pll_fraction_o}, 16'h2710);
		chk("frac bad", {15'h0000, pll_fraction_invalid_o}, 16'h0001);
	endtask
	task automatic t_vbat();
		for (int c = 0; c < 4; c++) begin
			host.wr(8'h0E, {3'h1, c[1:0], 3'h0});
			vbat_mv_i = 16'h09C3 + 16'h00C8 * c[15:0];
			step(2);
			chk("inhibit below", {15'h0000, passthrough_inhibit_o}, 16'h0001);
			vbat_mv_i = vbat_mv_i + 16'h0001;
			step(2);
			chk("inhibit at", {15'h0000, passthrough_inhibit_o}, 16'h0000);
		end
	endtask
	task automatic pk(input logic above, input logic exp);
		peak_above_i = above;
		peak_sample_i = 1'b1;
		step(1);
		peak_sample_i = 1'b0;
		chk("trigger", {15'h0000, limiter_trigger_o}, {15'h0000, exp});
		step(1);
		chk("trigger drop", {15'h0000, limiter_trigger_o}, 16'h0000);
	endtask
	task automatic t_integ();
		pk(1'b1, 1'b1);
		host.wr(8'h10, 8'h02);
		pk(1'b1, 1'b0);
		pk(1'b1, 1'b0);
		pk(1'b1, 1'b1);
		host.wr(8'h10, 8'h42);
		pk(1'b1, 1'b0);
		pk(1'b1, 1'b0);
		for (int k = 0; k < 3; k++)
			pk(1'b0, 1'b0);
		pk(1'b1, 1'b1);
		pk(1'b1, 1'b0);
		pk(1'b1, 1'b0);
		for (int k = 0; k < 4; k++)
			pk(1'b0, 1'b0);
		pk(1'b1, 1'b0);
		pk(1'b1, 1'b1);
	endtask
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		step(4);
		sys_rst_i = 1'b0;
		t_reset();
		t_rw();
		t_scale();
		t_pdm();
		t_pll();
		t_vbat();
		t_integ();
		sys_rst_i = 1'b1;
		step(2);
		sys_rst_i = 1'b0;
		t_reset();
		end_sim();
	end
endmodule
